// file: brake_sequencer.sv
// External brake sequencer: sequencing, register port, interrupts
// What this block does
// R1 - Sequence runs only when enable setting is 01
// R2 - Run on: ramp up to release frequency
// R3 - Wait release delay before asserting release
// R4 - Low current at release: trip, fault out
// R5 - Release permitted only above minimum current
// R6 - Hold release frequency until confirm turns on
// R7 - After confirm, wait accel delay, then accelerate
// R8 - Confirm timeout after each release change
// R9 - Run off: decelerate, then drop release
// R10 - Hold frequency waiting confirm off; timeout trips
// R11 - After confirm off, wait stop delay, stop
// R12 - Release frequency setting spans 0 to 400 Hz
// R13 - Confirm on means brake not engaged
// R14 - Brake system reports release and engage truly
// R15 - Confirm assignable to any of eight inputs
// R16 - Delays in 10 ms steps; fault latches
// R17 - Timeouts use confirm timeout, not release delay
`timescale 1ns/1ps
`include "brake_consts.svh"
module brake_sequencer (
  input  wire logic        ref_clk,          // Control clock, 200 MHz
  input  wire logic        reset_n,          // Async reset, active low
  input  wire logic        run_cmd,          // Run command from drive logic
  input  wire logic        trip_reset,       // Trip reset pulse
  input  wire logic [7:0]  logic_inputs,     // Eight logic input pins
  input  wire logic [15:0] out_freq,         // Present output freq, 0.01 Hz
  input  wire logic [15:0] out_current,      // Output current, percent x 0.1
  input  wire logic        freq_reached,     // Ramp reached its command
  input  wire logic [7:0]  reg_addr,         // Register byte address
  input  wire logic [31:0] reg_wdata,        // Register write data
  input  wire logic        reg_wr,           // Write strobe
  input  wire logic        reg_rd,           // Read strobe
  output logic      [31:0] reg_rdata,        // Read data, one cycle later
  output logic             brake_release_out,// Brake release output
  output logic             brake_fault_out,  // Brake fault output
  output logic             trip_out,         // Drive trip
  output logic      [15:0] freq_cmd,         // Frequency command to ramp
  output logic             hold_ramp,        // Hold present frequency
  output logic             run_enable,       // Drive operating
  output logic             irq               // Level interrupt
);
  brake_pkg::seq_state_t state_q;            // Sequencer state
  brake_pkg::seq_state_t state_d;            // Next state
  logic [1:0]  enable_q;                     // Brake control enable setting
  logic [2:0]  confirm_sel_q;                // Terminal carrying confirm
  logic [15:0] release_delay_q;              // Release delay, ticks
  logic [15:0] accel_delay_q;                // Accel delay, ticks
  logic [15:0] stop_delay_q;                 // Stop delay, ticks
  logic [15:0] confirm_tmo_q;                // Confirm timeout, ticks
  logic [15:0] release_freq_q;               // Release frequency
  logic [15:0] release_cur_q;                // Release current
  logic [15:0] target_freq_q;                // Target frequency
  logic [15:0] timer_q;                      // Tick counter in state
  logic [`IRQ_BITS-1:0] irq_stat_q;          // Sticky events
  logic [`IRQ_BITS-1:0] irq_mask_q;          // Event mask
  logic [`IRQ_BITS-1:0] events;              // Event pulses
  logic [7:0]  pin_s1_q;                     // First sync stage
  logic [7:0]  pin_s2_q;                     // Second sync stage
  logic        confirm;                      // Brake not engaged when high
  logic        tick;                         // 10 ms enable
  logic        seq_on;                       // Sequence enabled
  logic        cur_ok;                       // Current above minimum
  logic        state_change;                 // State changes this cycle

  // Clamp a time setting to 5.00 s
  function automatic logic [15:0] clamp_time(input logic [31:0] v);
    clamp_time = (v[15:0] > `DELAY_MAX_TICKS) ? `DELAY_MAX_TICKS : v[15:0];
  endfunction

  // Delay expiry check
  function automatic logic expired(input logic [15:0] t, input logic [15:0] lim);
    expired = (t >= lim);
  endfunction

  tick_divider u_tick (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tick    (tick)
  );

  // Two-stage synchroniser for the input pins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      pin_s1_q <= logic_inputs;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign confirm = pin_s2_q[confirm_sel_q];                  // see R13 see R15
  assign seq_on  = (enable_q == `ENABLE_CODE_ON);            // see R1
  assign cur_ok  = (out_current > release_cur_q);            // see R5

  // Register writes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q        <= `ENABLE_CODE_OFF;
      confirm_sel_q   <= 3'h0;
      release_delay_q <= 16'h0000;
      accel_delay_q   <= 16'h0000;
      stop_delay_q    <= 16'h0000;
      confirm_tmo_q   <= 16'h0000;
      release_freq_q  <= 16'h0000;
      release_cur_q   <= 16'h0000;
      target_freq_q   <= 16'h0000;
      irq_mask_q      <= 4'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: begin
          enable_q      <= reg_wdata[1:0];
          confirm_sel_q <= reg_wdata[4:2];                   // see R15
          target_freq_q <= reg_wdata[31:16];
        end
        `REG_RELEASE_DLY:  release_delay_q <= clamp_time(reg_wdata); // see R3
        `REG_ACCEL_DLY:    accel_delay_q   <= clamp_time(reg_wdata); // see R7
        `REG_STOP_DLY:     stop_delay_q    <= clamp_time(reg_wdata); // see R11
        `REG_CONFIRM_TMO:  confirm_tmo_q   <= clamp_time(reg_wdata); // see R8
        `REG_RELEASE_FREQ: release_freq_q  <= (reg_wdata[15:0] > `RELEASE_FREQ_MAX) ?
                                              `RELEASE_FREQ_MAX : reg_wdata[15:0]; // see R12
        `REG_RELEASE_CUR:  release_cur_q   <= (reg_wdata[15:0] > `RELEASE_CUR_MAX) ?
                                              `RELEASE_CUR_MAX : reg_wdata[15:0]; // see R5
        `REG_IRQ_MASK:     irq_mask_q      <= reg_wdata[`IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle later
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:         reg_rdata <= {target_freq_q, 11'h0, confirm_sel_q, enable_q};
        `REG_RELEASE_DLY:  reg_rdata <= {16'h0, release_delay_q};
        `REG_ACCEL_DLY:    reg_rdata <= {16'h0, accel_delay_q};
        `REG_STOP_DLY:     reg_rdata <= {16'h0, stop_delay_q};
        `REG_CONFIRM_TMO:  reg_rdata <= {16'h0, confirm_tmo_q};
        `REG_RELEASE_FREQ: reg_rdata <= {16'h0, release_freq_q};
        `REG_RELEASE_CUR:  reg_rdata <= {16'h0, release_cur_q};
        `REG_STATUS:       reg_rdata <= {24'h0, confirm, brake_fault_out, brake_release_out, 1'b0, state_q};
        `REG_IRQ_STATUS:   reg_rdata <= {28'h0, irq_stat_q};
        `REG_IRQ_MASK:     reg_rdata <= {28'h0, irq_mask_q};
        default:           reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      brake_pkg::ST_IDLE:
        if (run_cmd && seq_on) state_d = brake_pkg::ST_RAMP_UP;   // see R1 see R2
        else if (run_cmd) state_d = brake_pkg::ST_RUNNING;
      brake_pkg::ST_RAMP_UP:
        if (!run_cmd) state_d = brake_pkg::ST_DECEL_ZERO;
        else if (freq_reached) state_d = brake_pkg::ST_REL_WAIT;  // see R2
      brake_pkg::ST_REL_WAIT:
        if (expired(timer_q, release_delay_q))                    // see R3 see R17
          state_d = cur_ok ? brake_pkg::ST_CONFIRM_ON : brake_pkg::ST_TRIPPED; // see R4
      brake_pkg::ST_CONFIRM_ON:
        if (confirm) state_d = brake_pkg::ST_ACCEL_WAIT;          // see R6
        else if (expired(timer_q, confirm_tmo_q)) state_d = brake_pkg::ST_TRIPPED; // see R8
      brake_pkg::ST_ACCEL_WAIT:
        if (expired(timer_q, accel_delay_q)) state_d = brake_pkg::ST_RUNNING; // see R7
      brake_pkg::ST_RUNNING:
        if (!run_cmd) state_d = seq_on ? brake_pkg::ST_RAMP_DOWN : brake_pkg::ST_DECEL_ZERO;
      brake_pkg::ST_RAMP_DOWN:
        if (freq_reached) state_d = brake_pkg::ST_CONFIRM_OFF;    // see R9
      brake_pkg::ST_CONFIRM_OFF:
        if (!confirm) state_d = brake_pkg::ST_STOP_WAIT;          // see R10
        else if (expired(timer_q, confirm_tmo_q)) state_d = brake_pkg::ST_TRIPPED; // see R8 see R17
      brake_pkg::ST_STOP_WAIT:
        if (expired(timer_q, stop_delay_q)) state_d = brake_pkg::ST_DECEL_ZERO; // see R11
      brake_pkg::ST_DECEL_ZERO:
        if (out_freq == 16'h0000) state_d = brake_pkg::ST_IDLE;
      brake_pkg::ST_TRIPPED:
        if (trip_reset) state_d = brake_pkg::ST_IDLE;             // see R16
      default: state_d = brake_pkg::ST_IDLE;
    endcase
  end

  assign state_change = (state_d != state_q);

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) state_q <= brake_pkg::ST_IDLE;
    else          state_q <= state_d;
  end

  // Delay timer counts 10 ms ticks, restarts per state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_q <= 16'h0000;
    end else if (state_change) begin
      timer_q <= 16'h0000;
    end else if (tick && timer_q != 16'hffff) begin
      timer_q <= timer_q + 16'h0001;                          // see R16
    end
  end

  // Brake release output, on from release until engage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      brake_release_out <= 1'b0;
    end else if (state_d == brake_pkg::ST_CONFIRM_ON && state_q == brake_pkg::ST_REL_WAIT) begin
      brake_release_out <= 1'b1;                              // see R3 see R5
    end else if (state_d == brake_pkg::ST_CONFIRM_OFF || state_d == brake_pkg::ST_TRIPPED) begin
      brake_release_out <= 1'b0;                              // see R4 see R9
    end
  end

  // Fault and trip latch until trip reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      brake_fault_out <= 1'b0;
      trip_out        <= 1'b0;
    end else if (state_d == brake_pkg::ST_TRIPPED) begin
      brake_fault_out <= 1'b1;                                // see R4 see R10 see R16
      trip_out        <= 1'b1;
    end else begin
      brake_fault_out <= 1'b0;
      trip_out        <= 1'b0;
    end
  end

  // Frequency command and ramp hold per state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      freq_cmd   <= 16'h0000;
      hold_ramp  <= 1'b0;
      run_enable <= 1'b0;
    end else begin
      case (state_d)
        brake_pkg::ST_RAMP_UP, brake_pkg::ST_RAMP_DOWN: begin
          freq_cmd <= release_freq_q;                         // see R2 see R9
          hold_ramp <= 1'b0;
          run_enable <= 1'b1;
        end
        brake_pkg::ST_REL_WAIT, brake_pkg::ST_CONFIRM_ON, brake_pkg::ST_ACCEL_WAIT,
        brake_pkg::ST_CONFIRM_OFF, brake_pkg::ST_STOP_WAIT: begin
          freq_cmd <= release_freq_q;                         // see R6 see R10
          hold_ramp <= 1'b1;
          run_enable <= 1'b1;
        end
        brake_pkg::ST_RUNNING: begin
          freq_cmd <= target_freq_q;                          // see R7
          hold_ramp <= 1'b0;
          run_enable <= 1'b1;
        end
        brake_pkg::ST_DECEL_ZERO: begin
          freq_cmd <= 16'h0000;                               // see R11
          hold_ramp <= 1'b0;
          run_enable <= 1'b1;
        end
        default: begin
          freq_cmd <= 16'h0000;
          hold_ramp <= 1'b0;
          run_enable <= 1'b0;
        end
      endcase
    end
  end

  // Event pulses
  assign events[`IRQ_RELEASE_BIT] = state_change && state_d == brake_pkg::ST_ACCEL_WAIT;
  assign events[`IRQ_ENGAGE_BIT]  = state_change && state_d == brake_pkg::ST_STOP_WAIT;
  assign events[`IRQ_FAULT_BIT]   = state_change && state_d == brake_pkg::ST_TRIPPED;
  assign events[`IRQ_DONE_BIT]    = state_change && state_d == brake_pkg::ST_IDLE;

  // Sticky status, write one to clear, set wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == `REG_IRQ_STATUS) ?
                     reg_wdata[`IRQ_BITS-1:0] : 4'h0)) | events;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Checks
  // Release not confirmed in time
  sequence confirm_late_s;
    (state_q == brake_pkg::ST_CONFIRM_ON) && !confirm && expired(timer_q, confirm_tmo_q);
  endsequence

  // Engage not confirmed in time
  sequence confirm_stuck_s;
    (state_q == brake_pkg::ST_CONFIRM_OFF) && confirm && expired(timer_q, confirm_tmo_q);
  endsequence

  disabled_run_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!seq_on && state_q == brake_pkg::ST_IDLE) |=> !brake_release_out) // see R1
    else $error("release asserted while disabled");
  low_current_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == brake_pkg::ST_REL_WAIT && expired(timer_q, release_delay_q) && !cur_ok)
    |=> (!brake_release_out && brake_fault_out && trip_out)) // see R4
    else $error("low current did not trip");
  release_current_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(brake_release_out) |-> $past(cur_ok)) // see R5
    else $error("release without current");
  hold_freq_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (brake_release_out && state_q == brake_pkg::ST_CONFIRM_ON) |-> (hold_ramp && freq_cmd == release_freq_q)) // see R6
    else $error("accelerating before confirm");
  confirm_tmo_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    confirm_late_s |=> (state_q == brake_pkg::ST_TRIPPED) ##0 brake_fault_out) // see R8
    else $error("confirm timeout missed");
  engage_tmo_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    confirm_stuck_s |=> (state_q == brake_pkg::ST_TRIPPED) ##0 (brake_fault_out && !brake_release_out)) // see R10
    else $error("engage timeout missed");
  engage_order_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == brake_pkg::ST_RAMP_DOWN && freq_reached) |=> !brake_release_out) // see R9
    else $error("release not dropped at stop");
  fault_latch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (brake_fault_out && !trip_reset) |=> brake_fault_out) // see R16
    else $error("fault dropped early");
  stop_wait_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == brake_pkg::ST_STOP_WAIT) |-> freq_cmd == release_freq_q) // see R11
    else $error("decelerated before stop delay");
endmodule // brake_sequencer

// file: brake_consts.svh
// Constants for the external brake sequencer
`ifndef BRAKE_CONSTS_SVH
`define BRAKE_CONSTS_SVH
`define CLK_FREQ_HZ        200000000
`define TICK_PERIOD_MS     10
`define TICK_CYCLES        ((`CLK_FREQ_HZ / 1000) * `TICK_PERIOD_MS)
`define DELAY_MAX_TICKS    16'h01f4
`define RELEASE_FREQ_MAX   16'h9c40
`define RELEASE_CUR_MAX    16'h07d0
`define ENABLE_CODE_ON     2'h1
`define ENABLE_CODE_OFF    2'h0
`define CONFIRM_OPT_CODE   8'h2c
`define TERMINAL_COUNT     8
`define SEL_WIDTH          3
`define FREQ_WIDTH         16
`define CUR_WIDTH          16
`define TIME_WIDTH         16
`define REG_CTRL           8'h00
`define REG_RELEASE_DLY    8'h04
`define REG_ACCEL_DLY      8'h08
`define REG_STOP_DLY       8'h0c
`define REG_CONFIRM_TMO    8'h10
`define REG_RELEASE_FREQ   8'h14
`define REG_RELEASE_CUR    8'h18
`define REG_STATUS         8'h1c
`define REG_IRQ_STATUS     8'h20
`define REG_IRQ_MASK       8'h24
`define IRQ_BITS           4
`define IRQ_RELEASE_BIT    0
`define IRQ_ENGAGE_BIT     1
`define IRQ_FAULT_BIT      2
`define IRQ_DONE_BIT       3
`endif

// file: brake_pkg.sv
// Types for the external brake sequencer
package brake_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RAMP_UP,
    ST_REL_WAIT,
    ST_CONFIRM_ON,
    ST_ACCEL_WAIT,
    ST_RUNNING,
    ST_RAMP_DOWN,
    ST_CONFIRM_OFF,
    ST_STOP_WAIT,
    ST_DECEL_ZERO,
    ST_TRIPPED
  } seq_state_t;
endpackage

// file: tick_divider.sv
// Divider giving a one-cycle 10 ms tick enable
`timescale 1ns/1ps
`include "brake_consts.svh"
module tick_divider (
  input  wire logic ref_clk,   // Control clock
  input  wire logic reset_n,   // Async reset, active low
  output logic      tick       // One-cycle pulse every 10 ms
);
  localparam int unsigned TICKS = `TICK_CYCLES;
  logic [20:0] cnt_q;          // Cycle counter

  // Count cycles and pulse at wrap
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 21'h0;
      tick  <= 1'b0;
    end else if (cnt_q == 21'(TICKS - 1)) begin
      cnt_q <= 21'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 21'h1;
      tick  <= 1'b0;
    end
  end
endmodule // tick_divider

// file: brake_model.sv
// Behavioural external brake with a confirmation contact
`timescale 1ns/1ps
module brake_model (
  input  wire logic        ref_clk,     // Control clock
  input  wire logic        reset_n,     // Async reset, active low
  input  wire logic        release_cmd, // Release command from drive
  input  wire logic [15:0] lag,         // Mechanical lag in cycles
  output logic             confirm      // High while brake is open
);
  logic [15:0] cnt_q; // Cycles since command changed
  // Contact follows the command once the lag has run out
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q   <= 16'h0000;
      confirm <= 1'b0; // Engaged at rest
    end else if (confirm == release_cmd) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q >= lag) begin
      confirm <= release_cmd; // True brake state
      cnt_q   <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule // brake_model

// file: testbench.sv
// Self-checking bench for the brake sequencer
`timescale 1ns/1ps
`include "brake_consts.svh"
module testbench;
  logic        ref_clk      = 1'b0;     // 200 MHz clock
  logic        reset_n      = 1'b0;     // Async reset
  logic        run_cmd      = 1'b0;     // Run request
  logic        trip_reset   = 1'b0;     // Trip clear
  logic [7:0]  logic_inputs = 8'h00;    // Input pins
  logic [15:0] out_freq     = 16'h0000; // Ramp output
  logic [15:0] out_current  = 16'h0000; // Motor current
  logic [7:0]  reg_addr     = 8'h00;    // Register address
  logic [31:0] reg_wdata    = 32'h0;    // Write data
  logic        reg_wr       = 1'b0;     // Write strobe
  logic        reg_rd       = 1'b0;     // Read strobe
  logic [31:0] reg_rdata;               // Read data
  logic        brake_release_out;       // Release output
  logic        brake_fault_out;         // Fault output
  logic        trip_out;                // Trip
  logic [15:0] freq_cmd;                // Frequency command
  logic        hold_ramp;               // Ramp hold
  logic        run_enable;              // Operating
  logic        irq;                     // Interrupt
  logic        confirm;                 // Brake contact
  logic [2:0]  sel          = 3'h0;     // Confirm terminal
  logic [7:0]  noise        = 8'h00;    // Other pins
  logic [3:0]  ramp_cnt     = 4'h0;     // Ramp settle count
  wire logic   freq_reached = (out_freq == freq_cmd); // Ramp at command
  int          errors       = 0;        // Mismatches
  int          checked      = 0;        // Comparisons
  int          n;                       // Wait counter
  int          rel_f, tgt_f, thr;       // Model settings

  // Clock generator
  always #2.5 ref_clk = ~ref_clk;

  // Ramp stand-in: output follows the command after a few cycles
  always @(posedge ref_clk) begin
    ramp_cnt <= freq_reached ? 4'h0 : ramp_cnt + 4'h1;
    if (ramp_cnt == 4'h6) out_freq <= freq_cmd;
  end

  // Pins: contact on the chosen terminal, noise on the rest
  always @(posedge ref_clk) logic_inputs <= (noise & ~(8'h01 << sel)) | ({7'h00, confirm} << sel);

  brake_sequencer DUT (.ref_clk(ref_clk), .reset_n(reset_n), .run_cmd(run_cmd), .trip_reset(trip_reset),
    .logic_inputs(logic_inputs), .out_freq(out_freq), .out_current(out_current), .freq_reached(freq_reached),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .brake_release_out(brake_release_out), .brake_fault_out(brake_fault_out), .trip_out(trip_out),
    .freq_cmd(freq_cmd), .hold_ramp(hold_ramp), .run_enable(run_enable), .irq(irq));

  brake_model brake (.ref_clk(ref_clk), .reset_n(reset_n), .release_cmd(brake_release_out),
    .lag(16'h0028), .confirm(confirm));

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Register read, data compared in the following cycle
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp, msg);
  endtask

  // Conditions that the bounded wait can look for
  function automatic bit cond(input int k);
    case (k)
      0: return brake_release_out === 1'b1;
      1: return freq_cmd === tgt_f[15:0];
      2: return brake_release_out === 1'b0;
      3: return run_enable === 1'b0;
      default: return trip_out === 1'b1;
    endcase
  endfunction

  // Bounded wait; running out ends the run
  task automatic wait_for(input int k);
    for (n = 0; n < 5000 && !cond(k); n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n >= 5000) begin
      errors++;
      $display("mismatch at %0t: wait %0d ran out", $time, k);
      tally_and_finish();
    end
  endtask

  // One run and stop on terminal s; enable code en
  task automatic run_cycle(input logic [2:0] s, input logic [1:0] en);
    sel         <= s;
    noise       <= 8'($urandom);
    out_current <= 16'(thr + 1 + $urandom % 100);
    tgt_f = rel_f + 1 + $urandom % 1000;
    wr(`REG_CTRL, {tgt_f[15:0], 11'h000, s, en});
    run_cmd <= 1'b1;
    if (en == `ENABLE_CODE_ON) begin
      wait_for(0);
      check(freq_cmd, rel_f, "ramp to release freq");
      repeat (20) @(posedge ref_clk);
      #1 check({hold_ramp, freq_cmd}, {1'b1, rel_f[15:0]}, "hold before confirm");
    end
    wait_for(1);
    check({brake_release_out, hold_ramp, run_enable}, {(en == `ENABLE_CODE_ON), 2'b01}, "release while running");
    run_cmd <= 1'b0;
    if (en == `ENABLE_CODE_ON) begin
      wait_for(2);
      check(freq_cmd, rel_f, "release drop at release freq");
      repeat (20) @(posedge ref_clk);
      #1 check({hold_ramp, freq_cmd}, {1'b1, rel_f[15:0]}, "hold while engaging");
    end
    wait_for(3);
    check(freq_cmd, 0, "stopped at zero");
  endtask

  // Main sequence; timer ticks are 10 ms, so delays are set to zero
  initial begin
    void'($urandom(1774));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 check({brake_release_out, brake_fault_out, trip_out, irq}, 0, "outputs after reset");
    rel_f = 1 + $urandom % 40000;
    thr   = $urandom % 2001;
    wr(`REG_STOP_DLY, 32'h258);
    rdc(`REG_STOP_DLY, 32'h1f4, "delay clamp");
    wr(`REG_RELEASE_FREQ, 32'hc350);
    rdc(`REG_RELEASE_FREQ, 32'h9c40, "freq clamp");
    wr(`REG_RELEASE_CUR, 32'hbb8);
    rdc(`REG_RELEASE_CUR, 32'h7d0, "current clamp");
    rdc(8'h28, 32'h0, "unmapped read");
    wr(`REG_RELEASE_DLY, 32'h0);
    wr(`REG_ACCEL_DLY, 32'h0);
    wr(`REG_STOP_DLY, 32'h0);
    wr(`REG_CONFIRM_TMO, 32'h1f4);
    wr(`REG_RELEASE_FREQ, rel_f);
    wr(`REG_RELEASE_CUR, thr);
    rdc(`REG_RELEASE_FREQ, rel_f, "freq readback");
    $display("test registers done");
    run_cycle(3'h0, `ENABLE_CODE_ON);
    check(irq, 1'b0, "masked events");
    rdc(`REG_IRQ_STATUS, 32'hb, "events of a run");
    wr(`REG_IRQ_MASK, 32'h8);
    #1 check(irq, 1'b1, "unmasked event");
    wr(`REG_IRQ_STATUS, 32'hf);
    #1 check(irq, 1'b0, "cleared event");
    for (int t = 1; t < `TERMINAL_COUNT; t++) begin
      run_cycle(3'(t), `ENABLE_CODE_ON);
    end
    $display("test terminals done");
    run_cycle(3'h5, `ENABLE_CODE_OFF);
    $display("test disabled done");
    wr(`REG_CTRL, {16'h1000, 11'h000, 3'h2, `ENABLE_CODE_ON});
    wr(`REG_IRQ_STATUS, 32'hf);
    wr(`REG_IRQ_MASK, 32'h4);
    out_current <= thr[15:0];
    run_cmd     <= 1'b1;
    wait_for(4);
    check({brake_release_out, brake_fault_out}, 2'b01, "low current trip");
    run_cmd <= 1'b0;
    repeat (30) @(posedge ref_clk);
    #1 check({trip_out, brake_fault_out, irq}, 3'b111, "fault latched");
    rdc(`REG_IRQ_STATUS, 32'h4, "fault event");
    trip_reset <= 1'b1;
    @(posedge ref_clk);
    trip_reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check({trip_out, brake_fault_out}, 2'b00, "trip cleared");
    $display("test fault done");
    // Zero confirm timeout: trip right after release
    tgt_f = rel_f + 1;
    out_current <= 16'(thr + 1);
    wr(`REG_CTRL, {tgt_f[15:0], 11'h000, 3'h5, `ENABLE_CODE_ON});
    wr(`REG_CONFIRM_TMO, 32'h0);
    run_cmd <= 1'b1;
    wait_for(4);
    check({brake_release_out, brake_fault_out, trip_out}, 3'b011, "confirm on timeout");
    run_cmd    <= 1'b0;
    trip_reset <= 1'b1;
    @(posedge ref_clk);
    trip_reset <= 1'b0;
    // Timeout cut to zero while running: trip while engaging
    wr(`REG_CONFIRM_TMO, 32'h1f4);
    run_cmd <= 1'b1;
    wait_for(1);
    wr(`REG_CONFIRM_TMO, 32'h0);
    run_cmd <= 1'b0;
    wait_for(4);
    check({brake_release_out, brake_fault_out, trip_out}, 3'b011, "confirm off timeout");
    trip_reset <= 1'b1;
    @(posedge ref_clk);
    trip_reset <= 1'b0;
    $display("test timeouts done");
    tally_and_finish();
  end
endmodule // testbench
